// File: rtl/ebpm_cfg.svh
/*
  Constants of the external bus port multiplexer: timing counts, request word
  field positions and reset values. Assumes a single core clock domain.
*/
`ifndef EBPM_CFG_SVH
`define EBPM_CFG_SVH

// ==========================================================================
// Clock and timing.
`define EBPM_CLK_NS      50
`define EBPM_BOOST_NS    100
`define EBPM_BOOST_CYC   ((`EBPM_BOOST_NS + `EBPM_CLK_NS - 1) / `EBPM_CLK_NS)
`define EBPM_ADDR_CYC    3'h2
`define EBPM_LATCH_CYC   3'h1
`define EBPM_SETUP_CYC   3'h1
`define EBPM_STROBE_CYC  3'h3
`define EBPM_HOLD_CYC    3'h1

// ==========================================================================
// Request word layout.
`define EBPM_REQ_W       30
`define EBPM_WDATA_HI    7
`define EBPM_WDATA_LO    0
`define EBPM_ADDR_HI     25
`define EBPM_ADDR_LO     8
`define EBPM_WIDTH_HI    27
`define EBPM_WIDTH_LO    26
`define EBPM_KIND_HI     29
`define EBPM_KIND_LO     28

// ==========================================================================
// Values.
`define EBPM_LATCH_RST   8'hff
`define EBPM_BUS_FILL    8'hff
`define EBPM_RDSEL_PROGRAM_STORE_STROBE_N  2'h2
`define EBPM_FIFO_DEPTH  16

`endif

// File: rtl/ebpm_pkg.sv
/*
  Types of the external bus port multiplexer.
  Assumes the constants header is included by the modules that use it.
*/
package ebpm_pkg;

  // ========================================================================
  // Enumerations.
  typedef enum logic [1:0] {
    EBPM_FETCH = 2'h0,
    EBPM_READ  = 2'h1,
    EBPM_WRITE = 2'h2,
    EBPM_RSVD  = 2'h3
  } ebpm_kind_type;

  typedef enum logic [1:0] {
    EBPM_W8  = 2'h0,
    EBPM_W16 = 2'h1,
    EBPM_W17 = 2'h2,
    EBPM_W18 = 2'h3
  } ebpm_width_type;

  typedef enum logic [5:0] {
    EBPM_IDLE   = 6'h01,
    EBPM_ADDR   = 6'h02,
    EBPM_LATCH  = 6'h04,
    EBPM_SETUP  = 6'h08,
    EBPM_STROBE = 6'h10,
    EBPM_HOLD   = 6'h20
  } ebpm_state_type;

endpackage

// File: rtl/ebpm_stream_if.sv
/*
  Valid/ready carrier between the request FIFO and the bus sequencer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ebpm_stream_if #(
  parameter int WIDTH = 30
);
  logic             inValid;
  logic             inReady;
  logic [WIDTH-1:0] inData;
  logic             outValid;
  logic             outReady;
  logic [WIDTH-1:0] outData;

  modport fifo (
    input  inValid,
    input  inData,
    input  outReady,
    output inReady,
    output outValid,
    output outData
  );

  modport user (
    output inValid,
    output inData,
    output outReady,
    input  inReady,
    input  outValid,
    input  outData
  );
endinterface

// File: rtl/ebpm_fifo.sv
/*
  Request FIFO of flip-flops, width and depth set by parameters.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module ebpm_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rstn,
  // Stream carrier.
  ebpm_stream_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gCheck
    $error("ebpm_fifo depth must be a power of two of at least two.");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        notFull;
    logic                        notEmpty;
  } fifo_state_type;

  fifo_state_type st;
  fifo_state_type next_st;
  logic           push;
  logic           pop;

  // ========================================================================
  // Next state.
  always_comb begin
    next_st = st;
    push = q.inValid && st.notFull;
    pop = st.notEmpty && q.outReady;
    if (push) begin
      next_st.mem[st.wr] = q.inData;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    next_st.notFull = (next_st.cnt != FULL);
    next_st.notEmpty = (next_st.cnt != '0);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{notFull: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign q.inReady = st.notFull;
  assign q.outValid = st.notEmpty;
  assign q.outData = st.mem[st.rd];
endmodule

// File: rtl/ebpm_top.sv
/*
  External bus port multiplexer: turns the low and high 8-bit ports into the
  external memory bus, keeps the port latches and their pin drivers, and
  sequences address latch, strobes and data on request.
  Assumes pads resolve out/oe pairs, requests come from logic on core_clk and
  external memory answers within the strobe time.
*/
`timescale 1ns/1ps
`include "ebpm_cfg.svh"

// Overview of operation
// - Read-modify-write latch update; pins follow next instruction.
// - Rising high latch bit boosts pullup two periods.
// - Nonpage: high port upper address, low multiplexed.
// - Page: low port lower address, high multiplexed.
// - Every bus cycle loads ones into low latch.
// - High latch kept; unused high pins show it.
// - Nonpage read: low port released.
// - Page read: high port released.
// - Bus mode low port drives both levels.
// - Instruction fetch uses program-store strobe.
// - Data read strobe chosen by configuration.
// - Fetch address 16, 17 or 18 bits.
// - Data address width follows instruction form.
// - Address valid when address latch pulse falls.
// - Write data before strobe, held past release.
// - Bus cycle drives pins from address/data path.
module ebpm_top
  import ebpm_pkg::*;
#(
  parameter int FIFO_DEPTH = `EBPM_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  // Configuration.
  input  wire logic                   pageMode,
  input  wire ebpm_width_type         extAddrCfg,
  input  wire logic [1:0]             readStrobeSelectCfg,
  // Bus requests and answers.
  input  wire logic                   reqValid,
  input  wire logic [`EBPM_REQ_W-1:0] reqData,
  output logic                        reqReady,
  output logic                        respValid,
  output logic [7:0]                  respData,
  output logic                        busBusy,
  // Port latch access.
  input  wire logic                   latchWrite,
  input  wire logic                   latchSelHigh,
  input  wire logic                   latchRmw,
  input  wire logic [7:0]             latchData,
  input  wire logic                   instrStart,
  output logic [7:0]                  lowPortLatch,
  output logic [7:0]                  highPortLatch,
  // Pins.
  input  wire logic [7:0]             lowPortIn,
  output logic [7:0]                  lowPortOut,
  output logic [7:0]                  lowPortOe,
  input  wire logic [7:0]             highPortIn,
  output logic [7:0]                  highPortOut,
  output logic [7:0]                  highPortOe,
  output logic [7:0]                  boostPullup,
  output logic [1:0]                  addrExtOut,
  output logic [1:0]                  addrExtOe,
  output logic                        aleOut,
  output logic                        programStoreStrobeN,
  output logic                        readStrobeN,
  output logic                        writeStrobeN
);

  if (`EBPM_BOOST_CYC < 1 || `EBPM_BOOST_CYC > 3 || FIFO_DEPTH < 2) begin : gCheck
    $error("ebpm_top boost count or FIFO depth out of range.");
  end

  typedef struct packed {
    ebpm_state_type         state;
    logic [2:0]             cnt;
    logic [`EBPM_REQ_W-1:0] req;
    logic [7:0]             lowLatch;
    logic [7:0]             highLatch;
    logic [7:0]             lowDrv;
    logic [7:0]             highDrv;
    logic                   lowPend;
    logic                   lowRmw;
    logic                   highPend;
    logic                   highRmw;
    logic [7:0][1:0]        boostCnt;
    logic [7:0]             boost;
    logic [7:0]             lowSync1;
    logic [7:0]             lowSync2;
    logic [7:0]             highSync1;
    logic [7:0]             highSync2;
    logic [7:0]             lowOut;
    logic [7:0]             lowOe;
    logic [7:0]             highOut;
    logic [7:0]             highOe;
    logic [1:0]             extOut;
    logic [1:0]             extOe;
    logic                   ale;
    logic                   psenN;
    logic                   rdN;
    logic                   wrN;
    logic                   respValid;
    logic [7:0]             respData;
    logic                   busy;
  } top_state_type;

  top_state_type  st;
  top_state_type  next_st;
  ebpm_stream_if #(.WIDTH(`EBPM_REQ_W)) reqQ ();

  // ========================================================================
  // Helpers.
  function automatic logic [2:0] phaseLen(input ebpm_state_type s);
    unique case (s)
      EBPM_ADDR:   phaseLen = `EBPM_ADDR_CYC - 3'h1;
      EBPM_LATCH:  phaseLen = `EBPM_LATCH_CYC - 3'h1;
      EBPM_SETUP:  phaseLen = `EBPM_SETUP_CYC - 3'h1;
      EBPM_STROBE: phaseLen = `EBPM_STROBE_CYC - 3'h1;
      EBPM_HOLD:   phaseLen = `EBPM_HOLD_CYC - 3'h1;
      EBPM_IDLE:   phaseLen = 3'h0;
    endcase
  endfunction

  // Fetches ignore the request's width and use the bus configuration, with 8 bits raised to 16.
  function automatic ebpm_width_type effWidth(input ebpm_kind_type k,
                                              input ebpm_width_type w,
                                              input ebpm_width_type cfg);
    if (k == EBPM_FETCH) begin
      effWidth = (cfg == EBPM_W8) ? EBPM_W16 : cfg;
    end else begin
      effWidth = w;
    end
  endfunction

  // ========================================================================
  // Request FIFO.
  assign reqQ.inValid = reqValid;
  assign reqQ.inData = reqData;
  assign reqQ.outReady = (st.state == EBPM_IDLE);

  ebpm_fifo #(
    .WIDTH (`EBPM_REQ_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .core_clk (core_clk),
    .rstn     (rstn),
    .q        (reqQ.fifo)
  );

  // ========================================================================
  // Next state.
  always_comb begin
    ebpm_kind_type  kind;
    ebpm_width_type width;
    logic [17:0]    addr;
    logic [7:0]     wdata;
    logic           dataPhase;
    logic           hiValid;
    logic [7:0]     rise;
    next_st = st;
    kind = EBPM_FETCH;
    width = EBPM_W8;
    addr = '0;
    wdata = '0;
    dataPhase = 1'b0;
    hiValid = 1'b0;
    rise = '0;
    next_st.respValid = 1'b0;
    next_st.lowSync1 = lowPortIn;
    next_st.lowSync2 = st.lowSync1;
    next_st.highSync1 = highPortIn;
    next_st.highSync2 = st.highSync1;

    // Plain writes reach the pins on the next edge; read-modify-write
    // updates wait for the start of the following instruction.
    if (st.lowPend && (!st.lowRmw || instrStart)) begin
      next_st.lowDrv = st.lowLatch;
      next_st.lowPend = 1'b0;
    end
    if (st.highPend && (!st.highRmw || instrStart)) begin
      next_st.highDrv = st.highLatch;
      next_st.highPend = 1'b0;
    end
    if (latchWrite && !latchSelHigh) begin
      next_st.lowLatch = latchData;
      next_st.lowPend = 1'b1;
      next_st.lowRmw = latchRmw;
    end
    if (latchWrite && latchSelHigh) begin
      next_st.highLatch = latchData;
      next_st.highPend = 1'b1;
      next_st.highRmw = latchRmw;
    end

    // Sequencer.
    kind = ebpm_kind_type'(st.req[`EBPM_KIND_HI:`EBPM_KIND_LO]);
    unique case (st.state)
      EBPM_IDLE: begin
        if (reqQ.outValid) begin
          next_st.req = reqQ.outData;
          next_st.state = EBPM_ADDR;
          next_st.cnt = phaseLen(EBPM_ADDR);
          // The bus fill beats a software write in the same cycle.
          next_st.lowLatch = `EBPM_BUS_FILL;
          next_st.lowPend = 1'b1;
          next_st.lowRmw = 1'b0;
        end
      end
      EBPM_ADDR, EBPM_LATCH, EBPM_SETUP, EBPM_HOLD: begin
        if (st.cnt != 3'h0) begin
          next_st.cnt = st.cnt - 3'h1;
        end else begin
          unique case (st.state)
            EBPM_ADDR:  next_st.state = EBPM_LATCH;
            EBPM_LATCH: next_st.state = EBPM_SETUP;
            EBPM_SETUP: next_st.state = EBPM_STROBE;
            default:    next_st.state = EBPM_IDLE;
          endcase
          next_st.cnt = phaseLen(next_st.state);
        end
      end
      EBPM_STROBE: begin
        if (st.cnt != 3'h0) begin
          next_st.cnt = st.cnt - 3'h1;
        end else begin
          next_st.state = EBPM_HOLD;
          next_st.cnt = phaseLen(EBPM_HOLD);
          next_st.respValid = 1'b1;
          // Read data is sampled through the synchronisers at strobe end.
          if (kind == EBPM_WRITE) begin
            next_st.respData = '0;
          end else if (pageMode) begin
            next_st.respData = st.highSync2;
          end else begin
            next_st.respData = st.lowSync2;
          end
        end
      end
    endcase

    // Boost pull-up on each rising high latch bit.
    rise = next_st.highLatch & ~st.highLatch;
    for (int i = 0; i < 8; i++) begin
      if (rise[i]) begin
        next_st.boostCnt[i] = 2'(`EBPM_BOOST_CYC);
      end else if (st.boostCnt[i] != 2'h0) begin
        next_st.boostCnt[i] = st.boostCnt[i] - 2'h1;
      end
      next_st.boost[i] = (next_st.boostCnt[i] != 2'h0);
    end

    // Pin drive for the state being entered.
    kind = ebpm_kind_type'(next_st.req[`EBPM_KIND_HI:`EBPM_KIND_LO]);
    width = ebpm_width_type'(next_st.req[`EBPM_WIDTH_HI:`EBPM_WIDTH_LO]);
    width = effWidth(kind, width, extAddrCfg);
    addr = next_st.req[`EBPM_ADDR_HI:`EBPM_ADDR_LO];
    wdata = next_st.req[`EBPM_WDATA_HI:`EBPM_WDATA_LO];
    hiValid = (width != EBPM_W8);
    dataPhase = (next_st.state == EBPM_SETUP) || (next_st.state == EBPM_STROBE) ||
                (next_st.state == EBPM_HOLD);
    next_st.ale = (next_st.state == EBPM_ADDR);
    next_st.busy = (next_st.state != EBPM_IDLE);
    next_st.psenN = 1'b1;
    next_st.rdN = 1'b1;
    next_st.wrN = 1'b1;
    if (next_st.state == EBPM_STROBE) begin
      if (kind == EBPM_FETCH) begin
        next_st.psenN = 1'b0;
      end else if (kind == EBPM_WRITE) begin
        next_st.wrN = 1'b0;
      end else if (readStrobeSelectCfg == `EBPM_RDSEL_PROGRAM_STORE_STROBE_N) begin
        next_st.psenN = 1'b0;
      end else begin
        next_st.rdN = 1'b0;
      end
    end

    if (next_st.state == EBPM_IDLE) begin
      // Port mode: low port is open drain, high port drives only zeros.
      next_st.lowOut = '0;
      next_st.lowOe = ~next_st.lowDrv;
      next_st.highOut = next_st.highDrv;
      next_st.highOe = ~next_st.highDrv;
      next_st.extOut = '0;
      next_st.extOe = '0;
    end else begin
      // Unused high pins show the latch, which bus cycles never touch.
      next_st.highOut = hiValid ? addr[15:8] : next_st.highDrv;
      next_st.highOe = hiValid ? 8'hff : ~next_st.highDrv;
      next_st.extOut = addr[17:16];
      next_st.extOe = {width == EBPM_W18, width >= EBPM_W17};
      if (pageMode) begin
        next_st.lowOut = addr[7:0];
        next_st.lowOe = 8'hff;
        if (dataPhase && kind == EBPM_WRITE) begin
          next_st.highOut = wdata;
          next_st.highOe = 8'hff;
        end else if (dataPhase) begin
          next_st.highOe = '0;
        end
      end else begin
        next_st.lowOut = dataPhase ? wdata : addr[7:0];
        next_st.lowOe = 8'hff;
        if (dataPhase && kind != EBPM_WRITE) begin
          next_st.lowOe = '0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{state:     EBPM_IDLE,
              lowLatch:  `EBPM_LATCH_RST,
              highLatch: `EBPM_LATCH_RST,
              lowDrv:    `EBPM_LATCH_RST,
              highDrv:   `EBPM_LATCH_RST,
              highOut:   `EBPM_LATCH_RST,
              psenN:     1'b1,
              rdN:       1'b1,
              wrN:       1'b1,
              default:   '0};
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Outputs.
  assign reqReady = reqQ.inReady;
  assign respValid = st.respValid;
  assign respData = st.respData;
  assign busBusy = st.busy;
  assign lowPortLatch = st.lowLatch;
  assign highPortLatch = st.highLatch;
  assign lowPortOut = st.lowOut;
  assign lowPortOe = st.lowOe;
  assign highPortOut = st.highOut;
  assign highPortOe = st.highOe;
  assign boostPullup = st.boost;
  assign addrExtOut = st.extOut;
  assign addrExtOe = st.extOe;
  assign aleOut = st.ale;
  assign programStoreStrobeN = st.psenN;
  assign readStrobeN = st.rdN;
  assign writeStrobeN = st.wrN;
endmodule

// File: test/ebpm_top_props.sv
/*
  Pin-level assertions of the external bus port multiplexer.
  Assumes it is bound to ebpm_top and sees only its ports.
*/
`timescale 1ns/1ps
module ebpm_top_props (
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       rstn,
  // Configuration and latch access.
  input wire logic       pageMode,
  input wire logic [1:0] readStrobeSelectCfg,
  input wire logic       latchWrite,
  // Observed outputs.
  input wire logic [7:0] lowPortLatch,
  input wire logic [7:0] highPortLatch,
  input wire logic [7:0] lowPortOut,
  input wire logic [7:0] lowPortOe,
  input wire logic [7:0] highPortOe,
  input wire logic [7:0] boostPullup,
  input wire logic       busBusy,
  input wire logic       respValid,
  input wire logic       aleOut,
  input wire logic       programStoreStrobeN,
  input wire logic       readStrobeN,
  input wire logic       writeStrobeN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ====================
  // Boost shadow.
  logic [7:0] prevHigh;
  logic [7:0] riseNow;
  logic [7:0] riseLast;
  logic       rdLow;
  assign riseNow = highPortLatch & ~prevHigh;
  assign rdLow   = !(readStrobeN && programStoreStrobeN);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prevHigh <= 8'hff;
      riseLast <= 8'h00;
    end else begin
      prevHigh <= highPortLatch;
      riseLast <= riseNow;
    end
  end
  // ====================
  // Assertions.
  a_boost_two_cycles: assert property (boostPullup == (riseNow | riseLast))
    else $error("boost pulse not two cycles");
  a_low_read_release: assert property (rdLow && !pageMode |-> lowPortOe == 8'h00)
    else $error("low port driven during read");
  a_high_read_release: assert property (rdLow && pageMode |-> highPortOe == 8'h00)
    else $error("high port driven during read");
  a_ale_two_high: assert property ($rose(aleOut) |=> aleOut ##1 !aleOut)
    else $error("latch pulse length wrong");
  a_ale_addr_stable: assert property ($fell(aleOut) |-> $stable(lowPortOut))
    else $error("address moved at latch fall");
  a_bus_drive_both: assert property (aleOut |-> lowPortOe == 8'hff)
    else $error("low port not fully driven");
  a_write_data_setup: assert property ($fell(writeStrobeN) |-> lowPortOe == 8'hff
    && $stable(lowPortOut))
    else $error("write data not ready at strobe");
  a_write_data_hold: assert property ($rose(writeStrobeN) |-> lowPortOe == 8'hff
    && $stable(lowPortOut))
    else $error("write data lost before release");
  a_bus_low_ones: assert property ($rose(busBusy) |-> lowPortLatch == 8'hff)
    else $error("low latch not set to ones");
  a_bus_high_kept: assert property (busBusy && !$past(latchWrite) |-> $stable(highPortLatch))
    else $error("high latch changed by bus");
  a_program_store_strobe_n_select: assert property (readStrobeSelectCfg == 2'h2 |-> !$fell(readStrobeN))
    else $error("read strobe used when program strobe chosen");
  a_one_strobe: assert property (!(!readStrobeN && !programStoreStrobeN))
    else $error("both read strobes low");
  a_resp_at_release: assert property (respValid |-> $rose(readStrobeN)
    || $rose(programStoreStrobeN) || $rose(writeStrobeN))
    else $error("answer not at strobe release");
  c_read: cover property ($fell(readStrobeN));
  c_fetch: cover property ($fell(programStoreStrobeN));
  c_write: cover property ($fell(writeStrobeN));
endmodule

// File: test/ebpm_mem_model.sv
/*
  External program and data memory with its address latch.
  Assumes it resolves the pin levels from the device's out/enable pairs.
*/
`timescale 1ns/1ps
module ebpm_mem_model (
  // Clock and mode.
  input  wire logic       core_clk,
  input  wire logic       pageMode,
  // Device pin drivers.
  input  wire logic [7:0] lowPortOut,
  input  wire logic [7:0] lowPortOe,
  input  wire logic [7:0] highPortOut,
  input  wire logic [7:0] highPortOe,
  input  wire logic       aleOut,
  input  wire logic       programStoreStrobeN,
  input  wire logic       readStrobeN,
  input  wire logic       writeStrobeN,
  // Resolved pins.
  output logic      [7:0] lowPortIn,
  output logic      [7:0] highPortIn
);
  logic [7:0] mem [256];
  logic [7:0] addrLatch;
  logic [7:0] floatVal;
  logic [7:0] rdData;
  logic       alePrev;
  logic       wrPrev;
  logic       rdOn;
  initial begin
    floatVal  = 8'h00;
    addrLatch = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  always @(posedge core_clk) begin
    alePrev  <= aleOut;
    wrPrev   <= writeStrobeN;
    floatVal <= ~floatVal;
    if (alePrev && !aleOut) begin
      addrLatch <= lowPortOut;
    end
    if (writeStrobeN && !wrPrev) begin
      mem[addrLatch] <= pageMode ? highPortOut : lowPortOut;
    end
  end
  // A floating low port wanders, so stale data never passes for an answer.
  assign rdOn       = !(readStrobeN && programStoreStrobeN);
  assign rdData     = rdOn ? mem[addrLatch] : floatVal;
  assign lowPortIn  = (lowPortOe & lowPortOut) | (~lowPortOe & (pageMode ? floatVal : rdData));
  assign highPortIn = (highPortOe & highPortOut)
                      | (~highPortOe & (pageMode && rdOn ? rdData : 8'hff));
endmodule

// File: test/ebpm_top_tb.sv
/*
  Self-checking bench of the external bus port multiplexer.
  Assumes the memory model resolves the pins and the checker is bound here.
*/
`timescale 1ns/1ps
`include "ebpm_cfg.svh"
module ebpm_top_tb;
  import ebpm_pkg::*;
  logic                   core_clk, rstn, pageMode, reqValid, reqReady, respValid;
  ebpm_width_type         extAddrCfg;
  logic [1:0]             readStrobeSelectCfg, addrExtOut, addrExtOe, aExt;
  logic [`EBPM_REQ_W-1:0] reqData;
  logic                   busBusy, latchWrite, latchSelHigh, latchRmw, instrStart;
  logic [7:0]             respData, latchData, lowPortLatch, highPortLatch, boostPullup;
  logic [7:0]             lowPortIn, lowPortOut, lowPortOe, highPortIn, highPortOut, highPortOe;
  logic                   aleOut, programStoreStrobeN, readStrobeN, writeStrobeN, sawPs, sawRd;
  logic [7:0]             aLo, aHi;
  logic [17:0]            a;
  logic [9:0]             wexp [4] = '{10'h0a5, 10'h07e, 10'h17e, 10'h37e};
  int                     fails, checked, cyc, n, acc, got;
  ebpm_top uut (.core_clk, .rstn, .pageMode, .extAddrCfg, .readStrobeSelectCfg, .reqValid,
    .reqData, .reqReady, .respValid, .respData, .busBusy, .latchWrite, .latchSelHigh,
    .latchRmw, .latchData, .instrStart, .lowPortLatch, .highPortLatch, .lowPortIn,
    .lowPortOut, .lowPortOe, .highPortIn, .highPortOut, .highPortOe, .boostPullup,
    .addrExtOut, .addrExtOe, .aleOut, .programStoreStrobeN, .readStrobeN, .writeStrobeN);
  ebpm_mem_model farMem (.core_clk, .pageMode, .lowPortOut, .lowPortOe, .highPortOut,
    .highPortOe, .aleOut, .programStoreStrobeN, .readStrobeN, .writeStrobeN, .lowPortIn,
    .highPortIn);
  // ====================
  // Tasks.
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim;
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Holds the word until the FIFO takes it, then waits for the answer.
  task automatic xfer(input ebpm_kind_type k, input ebpm_width_type w,
                      input logic [17:0] ad, input logic [7:0] d);
    n = 0;
    sawPs = 1'b0;
    sawRd = 1'b0;
    reqData = {k, w, ad, d};
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    tick(1);
    reqValid = 1'b0;
    while (respValid !== 1'b1 && n < 80) begin
      tick(1);
      n++;
    end
    if (n >= 80) fails++;
  endtask
  task automatic wlatch(input logic hi, input logic rmw, input logic [7:0] d);
    latchSelHigh = hi;
    latchRmw = rmw;
    latchData = d;
    latchWrite = 1'b1;
    tick(1);
    latchWrite = 1'b0;
  endtask
  // ====================
  // Clock, monitor and timeout.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (aleOut) begin
      aLo  <= lowPortOut;
      aHi  <= highPortOut;
      aExt <= addrExtOut & addrExtOe;
    end
    if (!programStoreStrobeN) sawPs <= 1'b1;
    if (!readStrobeN) sawRd <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  // ====================
  // Tests.
  initial begin
    {rstn, pageMode, reqValid, latchWrite, latchSelHigh, latchRmw, instrStart} = '0;
    {fails, checked, cyc, sawPs, sawRd} = '0;
    extAddrCfg = EBPM_W18;
    readStrobeSelectCfg = 2'h0;
    reqData = '0;
    latchData = 8'h00;
    repeat (3) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    chk(highPortLatch, 8'hff);
    for (int pm = 0; pm < 2; pm++) begin
      pageMode = pm[0];
      a = 18'h2_a1c3 + 18'(pm);
      xfer(EBPM_FETCH, EBPM_W18, a, 8'h00);
      chk(respData, a[7:0] ^ 8'h5a);
      chk({aExt, aHi, aLo}, a);
      chk({sawPs, sawRd}, 2'b10);
      xfer(EBPM_WRITE, EBPM_W18, a, 8'h96 ^ 8'(pm));
      chk({aExt, aHi, aLo}, a);
      xfer(EBPM_READ, EBPM_W18, a, 8'h00);
      chk(respData, 8'h96 ^ 8'(pm));
    end
    pageMode = 1'b0;
    wlatch(1'b1, 1'b0, 8'ha5);
    tick(1);
    wlatch(1'b0, 1'b0, 8'h3c);
    chk(lowPortLatch, 8'h3c);
    for (int w = 0; w < 4; w++) begin
      xfer(EBPM_READ, ebpm_width_type'(w), 18'h3_7e11, 8'h00);
      chk({aExt, aHi}, wexp[w]);
      extAddrCfg = ebpm_width_type'(w);
      xfer(EBPM_FETCH, EBPM_W8, 18'h3_7e11, 8'h00);
      chk({aExt, aHi}, w == 0 ? 10'h07e : wexp[w]);
      chk(lowPortLatch, 8'hff);
      chk(highPortLatch, 8'ha5);
    end
    for (int c = 0; c < 4; c++) begin
      readStrobeSelectCfg = 2'(c);
      xfer(c == 3 ? EBPM_RSVD : EBPM_READ, EBPM_W16, 18'h0_0042, 8'h00);
      chk({sawPs, sawRd}, c == 2 ? 2'b10 : 2'b01);
      chk(respData, 8'h42 ^ 8'h5a);
    end
    wlatch(1'b1, 1'b0, 8'h00);
    tick(1);
    chk(highPortOut, 8'h00);
    wlatch(1'b1, 1'b1, 8'h3c);
    chk(boostPullup, 8'h3c);
    tick(2);
    chk(boostPullup, 8'h00);
    chk(highPortOut, 8'h00);
    instrStart = 1'b1;
    tick(1);
    instrStart = 1'b0;
    tick(1);
    chk(highPortOut, 8'h3c);
    // A full FIFO must refuse; every accepted word still gets its answer.
    reqData = {EBPM_FETCH, EBPM_W16, 18'h0_0100, 8'h00};
    reqValid = 1'b1;
    sawRd = 1'b0;
    {n, acc, got} = '0;
    while (reqReady === 1'b1 && n < 60) begin
      tick(1);
      if (respValid === 1'b1) got++;
      acc++;
      n++;
    end
    reqValid = 1'b0;
    chk(18'(acc >= 17), 18'h1);
    repeat (400) begin
      tick(1);
      if (respValid === 1'b1) got++;
    end
    chk(18'(got), 18'(acc));
    chk(sawRd, 1'b0);
    end_sim();
  end
endmodule

bind ebpm_top ebpm_top_props chk (.core_clk, .rstn, .pageMode, .readStrobeSelectCfg,
  .latchWrite, .lowPortLatch, .highPortLatch, .lowPortOut, .lowPortOe, .highPortOe,
  .boostPullup, .busBusy, .respValid, .aleOut, .programStoreStrobeN, .readStrobeN,
  .writeStrobeN);
